// >>> logic/tspm_top.sv
// Purpose: Segment window and pair matcher front end of the track processor
// Assumes: Segments arrive every crossing from another clock domain
// Notes: Quality outputs trail the inputs by PIPE_LATENCY crossings
// What this block does
// - Accept 15 endcap segments and 4 barrel segments every crossing.
// - Retime all incoming segments onto the local clock before pairing.
// - Next-crossing segments fill only slots left empty this crossing.
// - Window spans two crossings; results still reported every crossing.
// - Choose best three, six for station one and four for barrel, by input rank and time.
// - Current crossing segments win over next crossing segments.
// - Selection and reordering happen before storage and pairing.
// - Each selected segment carries a current-crossing flag.
// - All pairs tested in parallel; no station one to four pairs.
// - Eta test checks each segment lies inside the trigger region.
// - Eta values must agree with a vertex-pointing line within tolerance.
// - At least one segment must not be flagged beam-parallel.
// - Three eta conditions ANDed into one shared bit.
// - Station one eta result ORed with its same-chamber ghost partner.
// - Barrel-endcap units use only the endcap segment for eta.
// - Phi difference must agree with measured bend angles.
// - Phi difference compared with fixed thresholds dphi_lo and dphi_hi for coarse momentum.
// - Quality from a small programmable lookup of eta, phi, quality bits.
// - Quality two bits for station one and barrel pairs, one bit otherwise.
`timescale 1ns/1ns
module tspm_top import tspm_pkg::*; (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Segments from receivers and barrel finder
	input wire logic [N_ST1*SEG_W-1:0] endcap_station_one,
	input wire logic [N_STX*SEG_W-1:0] endcap_station_two,
	input wire logic [N_STX*SEG_W-1:0] endcap_station_three,
	input wire logic [N_STX*SEG_W-1:0] endcap_station_four,
	input wire logic [N_BAR*SEG_W-1:0] barrel_overlap_chamber,
	input wire logic [2:0] ghost_one,
	// Configuration
	input wire logic [ETA_W-1:0] eta_min,
	input wire logic [ETA_W-1:0] eta_max,
	input wire logic [ETA_W-1:0] eta_tol,
	input wire logic [BEND_W:0] bend_tol,
	input wire logic [PHI_W-1:0] dphi_lo,
	input wire logic [PHI_W-1:0] dphi_hi,
	input wire logic [(1<<LUT_IN_W)*2-1:0] qual_lut,
	// Selected segments toward the segment store
	output logic [(N_ENDCAP+N_BAR)*SEL_W-1:0] sel_segments,
	// Pair qualities
	output logic [N_ST1*N_STX*2-1:0] q_one_two,
	output logic [N_ST1*N_STX*2-1:0] q_one_three,
	output logic [N_STX*N_STX-1:0] q_two_three,
	output logic [N_STX*N_STX-1:0] q_two_four,
	output logic [N_STX*N_STX-1:0] q_three_four,
	output logic [N_BAR*N_STX*2-1:0] q_bar_two
);
	localparam int IN_W = (N_ENDCAP + N_BAR) * SEG_W;
	// ----------------------------------------
	// Input retiming
	// ----------------------------------------
	logic [IN_W-1:0] raw_in, sync1, sync2, prev;
	logic [2:0] gh1, gh2, gh_cur;
	assign raw_in = {barrel_overlap_chamber, endcap_station_four, endcap_station_three,
		endcap_station_two, endcap_station_one};
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sync1 <= '0;
			sync2 <= '0;
			gh1 <= '0;
			gh2 <= '0;
		end else begin
			sync1 <= raw_in;
			sync2 <= sync1;
			gh1 <= ghost_one;
			gh2 <= gh1;
		end
	end
	// Delay line: prev holds crossing N, sync2 holds crossing N+1
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			prev <= '0;
			gh_cur <= '0;
		end else begin
			prev <= sync2;
			gh_cur <= gh2;
		end
	end
	// ----------------------------------------
	// Crossing analysis per station
	// ----------------------------------------
	logic [N_ST1*SEL_W-1:0] s1;
	logic [N_STX*SEL_W-1:0] s2, s3, s4;
	logic [N_BAR*SEL_W-1:0] sb;
	tspm_window_sel #(.SLOTS(N_ST1)) u_sel1 (.clk(clk), .resetn(resetn),
		.cur_seg(prev[0 +: N_ST1*SEG_W]), .nxt_seg(sync2[0 +: N_ST1*SEG_W]),
		.sel_seg(s1));
	tspm_window_sel #(.SLOTS(N_STX)) u_sel2 (.clk(clk), .resetn(resetn),
		.cur_seg(prev[N_ST1*SEG_W +: N_STX*SEG_W]),
		.nxt_seg(sync2[N_ST1*SEG_W +: N_STX*SEG_W]), .sel_seg(s2));
	tspm_window_sel #(.SLOTS(N_STX)) u_sel3 (.clk(clk), .resetn(resetn),
		.cur_seg(prev[(N_ST1+N_STX)*SEG_W +: N_STX*SEG_W]),
		.nxt_seg(sync2[(N_ST1+N_STX)*SEG_W +: N_STX*SEG_W]), .sel_seg(s3));
	tspm_window_sel #(.SLOTS(N_STX)) u_sel4 (.clk(clk), .resetn(resetn),
		.cur_seg(prev[(N_ST1+2*N_STX)*SEG_W +: N_STX*SEG_W]),
		.nxt_seg(sync2[(N_ST1+2*N_STX)*SEG_W +: N_STX*SEG_W]), .sel_seg(s4));
	tspm_window_sel #(.SLOTS(N_BAR)) u_selb (.clk(clk), .resetn(resetn),
		.cur_seg(prev[N_ENDCAP*SEG_W +: N_BAR*SEG_W]),
		.nxt_seg(sync2[N_ENDCAP*SEG_W +: N_BAR*SEG_W]), .sel_seg(sb));
	// Ghost bits follow their segments through the selector and eta stages
	logic [2:0] gh_sel, gh_eta;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			gh_sel <= '0;
			gh_eta <= '0;
			sel_segments <= '0;
		end else begin
			gh_sel <= gh_cur;
			gh_eta <= gh_sel;
			sel_segments <= {sb, s4, s3, s2, s1};
		end
	end
	// ----------------------------------------
	// Extrapolation units, all in parallel
	// ----------------------------------------
	logic [N_ST1*N_STX-1:0] e12, e13;
	logic [N_STX*N_STX-1:0] e23, e24, e34;
	logic [N_BAR*N_STX-1:0] eb2;
	logic [N_ST1*N_STX*2-1:0] qo12, qo13;
	logic [N_STX*N_STX-1:0] qo23, qo24, qo34;
	logic [N_BAR*N_STX*2-1:0] qob2;
	genvar i, j;
	generate
		for (i = 0; i < N_ST1; i++) begin : g_one
			for (j = 0; j < N_STX; j++) begin : g_t
				// Partner is the other segment of the same concentrator
				localparam int P = i ^ 1;
				logic gp;
				assign gp = gh_eta[i/2] ? e12[P*N_STX+j] : 1'b0;
				logic gq;
				assign gq = gh_eta[i/2] ? e13[P*N_STX+j] : 1'b0;
				tspm_pair_unit #(.Q_W(2)) u12 (.clk(clk), .resetn(resetn),
					.seg_a(s1[i*SEL_W +: SEL_W]), .seg_b(s2[j*SEL_W +: SEL_W]),
					.eta_min(eta_min), .eta_max(eta_max), .eta_tol(eta_tol),
					.bend_tol(bend_tol), .dphi_lo(dphi_lo), .dphi_hi(dphi_hi),
					.qual_lut(qual_lut), .eta_partner(gp), .eta_ok(e12[i*N_STX+j]),
					.quality(qo12[(i*N_STX+j)*2 +: 2]));
				tspm_pair_unit #(.Q_W(2)) u13 (.clk(clk), .resetn(resetn),
					.seg_a(s1[i*SEL_W +: SEL_W]), .seg_b(s3[j*SEL_W +: SEL_W]),
					.eta_min(eta_min), .eta_max(eta_max), .eta_tol(eta_tol),
					.bend_tol(bend_tol), .dphi_lo(dphi_lo), .dphi_hi(dphi_hi),
					.qual_lut(qual_lut), .eta_partner(gq), .eta_ok(e13[i*N_STX+j]),
					.quality(qo13[(i*N_STX+j)*2 +: 2]));
			end
		end
		for (i = 0; i < N_STX; i++) begin : g_x
			for (j = 0; j < N_STX; j++) begin : g_t
				tspm_pair_unit #(.Q_W(1)) u23 (.clk(clk), .resetn(resetn),
					.seg_a(s2[i*SEL_W +: SEL_W]), .seg_b(s3[j*SEL_W +: SEL_W]),
					.eta_min(eta_min), .eta_max(eta_max), .eta_tol(eta_tol),
					.bend_tol(bend_tol), .dphi_lo(dphi_lo), .dphi_hi(dphi_hi),
					.qual_lut(qual_lut), .eta_partner(1'b0), .eta_ok(e23[i*N_STX+j]),
					.quality(qo23[i*N_STX+j +: 1]));
				tspm_pair_unit #(.Q_W(1)) u24 (.clk(clk), .resetn(resetn),
					.seg_a(s2[i*SEL_W +: SEL_W]), .seg_b(s4[j*SEL_W +: SEL_W]),
					.eta_min(eta_min), .eta_max(eta_max), .eta_tol(eta_tol),
					.bend_tol(bend_tol), .dphi_lo(dphi_lo), .dphi_hi(dphi_hi),
					.qual_lut(qual_lut), .eta_partner(1'b0), .eta_ok(e24[i*N_STX+j]),
					.quality(qo24[i*N_STX+j +: 1]));
				tspm_pair_unit #(.Q_W(1)) u34 (.clk(clk), .resetn(resetn),
					.seg_a(s3[i*SEL_W +: SEL_W]), .seg_b(s4[j*SEL_W +: SEL_W]),
					.eta_min(eta_min), .eta_max(eta_max), .eta_tol(eta_tol),
					.bend_tol(bend_tol), .dphi_lo(dphi_lo), .dphi_hi(dphi_hi),
					.qual_lut(qual_lut), .eta_partner(1'b0), .eta_ok(e34[i*N_STX+j]),
					.quality(qo34[i*N_STX+j +: 1]));
			end
		end
		for (i = 0; i < N_BAR; i++) begin : g_b
			for (j = 0; j < N_STX; j++) begin : g_t
				tspm_pair_unit #(.Q_W(2), .BARREL_A(1'b1)) ub2 (.clk(clk), .resetn(resetn),
					.seg_a(sb[i*SEL_W +: SEL_W]), .seg_b(s2[j*SEL_W +: SEL_W]),
					.eta_min(eta_min), .eta_max(eta_max), .eta_tol(eta_tol),
					.bend_tol(bend_tol), .dphi_lo(dphi_lo), .dphi_hi(dphi_hi),
					.qual_lut(qual_lut), .eta_partner(1'b0), .eta_ok(eb2[i*N_STX+j]),
					.quality(qob2[(i*N_STX+j)*2 +: 2]));
			end
		end
	endgenerate
	// ----------------------------------------
	// Output register
	// ----------------------------------------
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			q_one_two <= '0;
			q_one_three <= '0;
			q_two_three <= '0;
			q_two_four <= '0;
			q_three_four <= '0;
			q_bar_two <= '0;
		end else begin
			q_one_two <= qo12;
			q_one_three <= qo13;
			q_two_three <= qo23;
			q_two_four <= qo24;
			q_three_four <= qo34;
			q_bar_two <= qob2;
		end
	end
endmodule : tspm_top

// >>> inc/tspm_pkg.sv
// Purpose: Shared constants for the segment window and pair matcher
// Assumes: One crossing per clock edge
// Notes: Field layout of one segment word is fixed here
package tspm_pkg;
	// ----------------------------------------
	// Segment counts
	// ----------------------------------------
	localparam int N_ST1 = 6;
	localparam int N_STX = 3;
	localparam int N_BAR = 4;
	localparam int N_ENDCAP = 15;
	// ----------------------------------------
	// Segment word fields
	// ----------------------------------------
	localparam int PHI_W = 12;
	localparam int ETA_W = 6;
	localparam int BEND_W = 5;
	localparam int QUAL_W = 3;
	localparam int PHI_LSB = 0;
	localparam int ETA_LSB = 12;
	localparam int BEND_LSB = 18;
	localparam int QUAL_LSB = 23;
	localparam int BEAM_BIT = 26;
	localparam int VALID_BIT = 27;
	localparam int SEG_W = 28;
	localparam int SEL_W = SEG_W + 1;
	localparam int IN_TIME_BIT = SEG_W;
	// ----------------------------------------
	// Pipeline
	// ----------------------------------------
	localparam int SYNC_STAGES = 2;
	localparam int PIPE_LATENCY = 5;
	localparam int LUT_IN_W = 6;
endpackage : tspm_pkg

// >>> logic/tspm_window_sel.sv
// Purpose: Picks the best segments of one station from a two-crossing window
// Assumes: Inputs ranked best first, valid ones packed low
// Notes: Current crossing fills first, the next crossing tops up empty slots
`timescale 1ns/1ns
module tspm_window_sel import tspm_pkg::*; #(
	parameter int SLOTS = 3
) (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Segments of the current and next crossing
	input wire logic [SLOTS*SEG_W-1:0] cur_seg,
	input wire logic [SLOTS*SEG_W-1:0] nxt_seg,
	// Selected segments with the in-time flag on top
	output logic [SLOTS*SEL_W-1:0] sel_seg
);
	logic [SLOTS*SEL_W-1:0] next_sel;
	always_comb begin
		int k;
		k = 0;
		next_sel = '0;
		// Current crossing first, then next crossing into empty slots
		for (int i = 0; i < SLOTS; i++) begin
			if (cur_seg[i*SEG_W+VALID_BIT] && k < SLOTS) begin
				next_sel[k*SEL_W +: SEL_W] = {1'b1, cur_seg[i*SEG_W +: SEG_W]};
				k = k + 1;
			end
		end
		for (int i = 0; i < SLOTS; i++) begin
			if (nxt_seg[i*SEG_W+VALID_BIT] && k < SLOTS) begin
				next_sel[k*SEL_W +: SEL_W] = {1'b0, nxt_seg[i*SEG_W +: SEG_W]};
				k = k + 1;
			end
		end
	end
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sel_seg <= '0;
		end else begin
			sel_seg <= next_sel;
		end
	end
endmodule : tspm_window_sel

// >>> logic/tspm_pair_unit.sv
// Purpose: One extrapolation unit testing a segment pair between two stations
// Assumes: Thresholds and lookup contents are static while running
// Notes: Eta result leaves early for ghost sharing; quality follows a cycle later
`timescale 1ns/1ns
module tspm_pair_unit import tspm_pkg::*; #(
	parameter int Q_W = 1,
	parameter bit BARREL_A = 1'b0
) (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Segment pair
	input wire logic [SEL_W-1:0] seg_a,
	input wire logic [SEL_W-1:0] seg_b,
	// Configuration
	input wire logic [ETA_W-1:0] eta_min,
	input wire logic [ETA_W-1:0] eta_max,
	input wire logic [ETA_W-1:0] eta_tol,
	input wire logic [BEND_W:0] bend_tol,
	input wire logic [PHI_W-1:0] dphi_lo,
	input wire logic [PHI_W-1:0] dphi_hi,
	input wire logic [(1<<LUT_IN_W)*2-1:0] qual_lut,
	// Ghost partner eta result
	input wire logic eta_partner,
	// Results
	output logic eta_ok,
	output logic [Q_W-1:0] quality
);
	logic [ETA_W-1:0] ea, eb, ediff;
	logic [PHI_W-1:0] pa, pb, dphi;
	logic [BEND_W:0] bsum;
	logic in_a, in_b, both_ok, eta_fin;
	logic [1:0] phi_bits;
	logic [LUT_IN_W-1:0] lut_idx;
	assign ea = seg_a[ETA_LSB +: ETA_W];
	assign eb = seg_b[ETA_LSB +: ETA_W];
	assign pa = seg_a[PHI_LSB +: PHI_W];
	assign pb = seg_b[PHI_LSB +: PHI_W];
	// --------------------------------
	// Eta road
	// --------------------------------
	always_comb begin
		in_a = BARREL_A || (ea >= eta_min && ea <= eta_max);
		in_b = eb >= eta_min && eb <= eta_max;
		ediff = (ea > eb) ? ea - eb : eb - ea;
		both_ok = seg_a[VALID_BIT] && seg_b[VALID_BIT] && in_a && in_b
			&& (BARREL_A || ediff <= eta_tol)
			&& (!seg_b[BEAM_BIT] || (!BARREL_A && !seg_a[BEAM_BIT]));
	end
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			eta_ok <= 1'b0;
		end else begin
			eta_ok <= both_ok;
		end
	end
	assign eta_fin = eta_ok | eta_partner;
	// --------------------------------
	// Phi road
	// --------------------------------
	logic [PHI_W-1:0] dphi_r;
	logic [BEND_W:0] bsum_r;
	logic [QUAL_W-1:0] qa_r, qb_r;
	always_comb begin
		dphi = (pa > pb) ? pa - pb : pb - pa;
		bsum = {1'b0, seg_a[BEND_LSB +: BEND_W]} + {1'b0, seg_b[BEND_LSB +: BEND_W]};
	end
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			dphi_r <= '0;
			bsum_r <= '0;
			qa_r <= '0;
			qb_r <= '0;
		end else begin
			dphi_r <= dphi;
			bsum_r <= bsum;
			qa_r <= seg_a[QUAL_LSB +: QUAL_W];
			qb_r <= seg_b[QUAL_LSB +: QUAL_W];
		end
	end
	always_comb begin
		phi_bits[0] = (dphi_r <= dphi_hi)
			&& ({{(PHI_W-BEND_W-1){1'b0}}, bsum_r} + {{(PHI_W-BEND_W-1){1'b0}}, bend_tol}
			>= dphi_r[PHI_W-1:0]);
		phi_bits[1] = dphi_r <= dphi_lo;
		lut_idx = {eta_fin, phi_bits, qa_r[QUAL_W-1], qb_r[QUAL_W-1:QUAL_W-2]};
	end
	// --------------------------------
	// Quality lookup
	// --------------------------------
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			quality <= '0;
		end else begin
			quality <= qual_lut[lut_idx*2 +: Q_W];
		end
	end
endmodule : tspm_pair_unit

// >>> tb/tspm_rx_model.sv
// Purpose: Receiver boards and barrel finder feeding the matcher
// Assumes: Callers hand over ranked segments, valid ones packed low
// Notes: Outside a crossing every slot is invalid with churning contents
`timescale 1ns/1ns
module tspm_rx_model import tspm_pkg::*; (
	// Clock
	input wire logic clk,
	// Segment streams
	output logic [N_ST1*SEG_W-1:0] st1 = '0,
	output logic [N_STX*SEG_W-1:0] st2 = '0,
	output logic [N_STX*SEG_W-1:0] st3 = '0,
	output logic [N_STX*SEG_W-1:0] st4 = '0,
	output logic [N_BAR*SEG_W-1:0] bar = '0,
	output logic [2:0] ghost = 3'h0
);
	logic [N_ST1*SEG_W-1:0] h1;
	logic [N_STX*SEG_W-1:0] h2, h3, h4;
	logic [N_BAR*SEG_W-1:0] hb;
	logic [2:0] hg;
	logic pend = 1'h0;
	logic [26:0] noise = 27'h4C3A5B1;
	always @(posedge clk) begin
		noise <= {noise[25:0], noise[26] ^ noise[20]};
		if (pend) begin
			st1 <= h1;
			st2 <= h2;
			st3 <= h3;
			st4 <= h4;
			bar <= hb;
			ghost <= hg;
			pend <= 1'h0;
		end else begin
			st1 <= {N_ST1{1'h0, noise}};
			st2 <= {N_STX{1'h0, noise}};
			st3 <= {N_STX{1'h0, ~noise}};
			st4 <= {N_STX{1'h0, noise}};
			bar <= {N_BAR{1'h0, ~noise}};
			ghost <= ~ghost;
		end
	end
	task put(input logic [N_ST1*SEG_W-1:0] a1, input logic [N_STX*SEG_W-1:0] a2, a3, a4,
		input logic [N_BAR*SEG_W-1:0] ab, input logic [2:0] g);
		h1 = a1;
		h2 = a2;
		h3 = a3;
		h4 = a4;
		hb = ab;
		hg = g;
		pend = 1'h1;
		@(posedge clk);
		#1;
	endtask : put
endmodule : tspm_rx_model

// >>> tb/tspm_checker.sv
// Purpose: Port checks on the matcher top
// Assumes: Inputs carry no valid segment during reset
// Notes: Bound to tspm_top below
`timescale 1ns/1ns
module tspm_checker import tspm_pkg::*; (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Watched ports
	input wire logic [N_ST1*SEG_W-1:0] endcap_station_one,
	input wire logic [N_STX*SEG_W-1:0] endcap_station_two,
	input wire logic [N_BAR*SEG_W-1:0] barrel_overlap_chamber,
	input wire logic [(1<<LUT_IN_W)*2-1:0] qual_lut,
	input wire logic [(N_ENDCAP+N_BAR)*SEL_W-1:0] sel_segments,
	input wire logic [N_STX*N_STX-1:0] q_two_three,
	input wire logic [N_BAR*N_STX*2-1:0] q_bar_two
);
	localparam int SW = (N_ENDCAP+N_BAR)*SEL_W;
	localparam int IW = N_ST1*SEG_W;
	logic [3:0] up;
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			up <= 4'h0;
		end else if (up != 4'hF) begin
			up <= up + 4'h1;
		end
	end
	function automatic int vc(input logic [IW-1:0] v, input int n);
		int c = 0;
		for (int i = 0; i < n; i++) begin
			c += v[i*SEG_W+VALID_BIT];
		end
		return c;
	endfunction : vc
	function automatic int sc(input logic [SW-1:0] s, input int f, input int n, input int b);
		int c = 0;
		for (int i = f; i < f+n; i++) begin
			c += s[i*SEL_W+b];
		end
		return c;
	endfunction : sc
	function automatic int mn(input int a, input int b);
		return (a < b) ? a : b;
	endfunction : mn
	// Mode 1 flags in-time on empty slots, mode 0 flags gaps and late-before-current
	function automatic bit pk(input logic [SW-1:0] s, input bit m);
		int f[5] = '{0, 6, 9, 12, 15};
		int n[5] = '{6, 3, 3, 3, 4};
		bit ok = 1'h1;
		bit gap, late, v, t;
		for (int g = 0; g < 5; g++) begin
			gap = 1'h0;
			late = 1'h0;
			for (int i = f[g]; i < f[g]+n[g]; i++) begin
				v = s[i*SEL_W+VALID_BIT];
				t = s[i*SEL_W+IN_TIME_BIT];
				ok = ok && !(m ? (t && !v) : ((v && gap) || (v && t && late)));
				gap = gap || !v;
				late = late || (v && !t);
			end
		end
		return ok;
	endfunction : pk
	sequence lut_off;
		(qual_lut == '0) [*8];
	endsequence
	AST_RST_QUIET: assert property (disable iff (1'h0) !resetn |-> sel_segments == '0)
		else $error("selection not cleared in reset");
	AST_FLAG_VALID: assert property (pk(sel_segments, 1'h1))
		else $error("in-time flag on empty slot");
	AST_PACK_ORDER: assert property (pk(sel_segments, 1'h0))
		else $error("selected slots out of order");
	AST_ST1_FILL: assert property (up > 4'h7 |->
		sc(sel_segments, 0, 6, VALID_BIT) == mn(6, vc($past(endcap_station_one, 5), 6)
		+ vc($past(endcap_station_one, 4), 6))) else $error("station one fill wrong");
	AST_ST1_TIME: assert property (up > 4'h7 |->
		sc(sel_segments, 0, 6, IN_TIME_BIT) == mn(6, vc($past(endcap_station_one, 5), 6)))
		else $error("station one in-time count wrong");
	AST_ST2_FILL: assert property (up > 4'h7 |->
		sc(sel_segments, 6, 3, VALID_BIT) == mn(3, vc(IW'($past(endcap_station_two, 5)), 3)
		+ vc(IW'($past(endcap_station_two, 4)), 3))) else $error("station two fill wrong");
	AST_ST2_TIME: assert property (up > 4'h7 |->
		sc(sel_segments, 6, 3, IN_TIME_BIT) == mn(3, vc(IW'($past(endcap_station_two, 5)), 3)))
		else $error("station two in-time count wrong");
	AST_BAR_FILL: assert property (up > 4'h7 |->
		sc(sel_segments, 15, 4, VALID_BIT) == mn(4, vc(IW'($past(barrel_overlap_chamber, 5)), 4)
		+ vc(IW'($past(barrel_overlap_chamber, 4)), 4))) else $error("barrel fill wrong");
	AST_LUT_OFF: assert property (lut_off |-> q_two_three == '0 && q_bar_two == '0)
		else $error("quality set with empty table");
endmodule : tspm_checker
bind tspm_top tspm_checker i_chk (.clk(clk), .resetn(resetn), .qual_lut(qual_lut),
	.endcap_station_one(endcap_station_one), .endcap_station_two(endcap_station_two),
	.barrel_overlap_chamber(barrel_overlap_chamber), .sel_segments(sel_segments),
	.q_two_three(q_two_three), .q_bar_two(q_bar_two));

// >>> tb/tb_tspm_top.sv
// Purpose: Self-checking bench for the matcher top
// Assumes: Selection 3 and quality 5 edges after crossing N+1 is sampled
// Notes: Quality checks hold one pair for three crossings
`timescale 1ns/1ns
`define CHECK(g, e) begin n_tests++; if ((g) !== (e)) begin num_errors++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_tspm_top import tspm_pkg::*; ();
	logic clk = 1'h0;
	logic resetn;
	logic [5:0] eta_tol = 6'h02;
	logic [(1<<LUT_IN_W)*2-1:0] qual_lut = '0;
	int num_errors = 0;
	int n_tests = 0;
	wire logic [N_ST1*SEG_W-1:0] s1;
	wire logic [N_STX*SEG_W-1:0] s2, s3, s4;
	wire logic [N_BAR*SEG_W-1:0] sb;
	wire logic [2:0] gh;
	wire logic [(N_ENDCAP+N_BAR)*SEL_W-1:0] sel;
	wire logic [N_ST1*N_STX*2-1:0] q12, q13;
	wire logic [N_STX*N_STX-1:0] q23, q24, q34;
	wire logic [N_BAR*N_STX*2-1:0] qb2;
	logic [N_ST1*SEG_W-1:0] a1;
	logic [N_STX*SEG_W-1:0] a2, a3, a4;
	logic [N_BAR*SEG_W-1:0] ab;
	logic [2:0] g;
	logic [SEG_W-1:0] blank = {1'h0, 27'h2A6C3F1};
	logic [5:0] ea[5] = '{6'h14, 6'h02, 6'h14, 6'h14, 6'h14};
	logic [5:0] eb[5] = '{6'h14, 6'h02, 6'h1E, 6'h14, 6'h14};
	logic [4:0] ba = 5'h18;
	logic [4:0] bb = 5'h08;
	logic [4:0] ex = 5'h11;
	tspm_rx_model i_rx (.clk(clk), .st1(s1), .st2(s2), .st3(s3), .st4(s4), .bar(sb), .ghost(gh));
	tspm_top i_dut (.clk(clk), .resetn(resetn), .endcap_station_one(s1),
		.endcap_station_two(s2), .endcap_station_three(s3), .endcap_station_four(s4),
		.barrel_overlap_chamber(sb), .ghost_one(gh), .eta_min(6'h04), .eta_max(6'h38),
		.eta_tol(eta_tol), .bend_tol(6'h04), .dphi_lo(12'h010), .dphi_hi(12'h040),
		.qual_lut(qual_lut), .sel_segments(sel), .q_one_two(q12), .q_one_three(q13),
		.q_two_three(q23), .q_two_four(q24), .q_three_four(q34), .q_bar_two(qb2));
	initial begin
		forever #4 clk = ~clk;
	end
	function automatic logic [SEG_W-1:0] seg(input logic [11:0] p, input logic [5:0] e,
		input logic b, input logic [2:0] q);
		return {1'h1, b, q, 5'h00, e, p};
	endfunction : seg
	task clr();
		a1 = {N_ST1{blank}};
		a2 = {N_STX{blank}};
		a3 = a2;
		a4 = a2;
		ab = {N_BAR{blank}};
		g = 3'h0;
	endtask : clr
	task send(input int k);
		repeat (k) i_rx.put(a1, a2, a3, a4, ab, g);
	endtask : send
	task wait_n(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : wait_n
	task lut(input logic [(1<<LUT_IN_W)*2-1:0] v);
		@(posedge clk);
		qual_lut <= v;
		#1;
	endtask : lut
	task pair(input logic [5:0] e_a, e_b, input logic b_a, b_b, input logic [11:0] pb);
		clr();
		a2[0+:SEG_W] = seg(12'h000, e_a, b_a, 3'h7);
		a3[0+:SEG_W] = seg(pb, e_b, b_b, 3'h7);
		a4[0+:SEG_W] = seg(pb, e_b, b_b, 3'h7);
		send(3);
		wait_n(5);
	endtask : pair
	task end_sim();
		$display("comparisons %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : end_sim
	initial begin
		#20000;
		num_errors++;
		end_sim();
	end
	initial begin
		logic [N_ST1*SEG_W-1:0] e1;
		logic [N_STX*SEG_W-1:0] e2, n2;
		resetn <= 1'h0;
		clr();
		repeat (10) @(posedge clk);
		resetn <= 1'h1;
		wait_n(2);
		for (int i = 0; i < N_ST1; i++) a1[i*SEG_W+:SEG_W] = seg(12'(i), 6'h14, 1'h0, 3'(7-i));
		a2[0+:SEG_W] = seg(12'h100, 6'h14, 1'h0, 3'h5);
		e1 = a1;
		e2 = a2;
		send(1);
		clr();
		a1[0+:SEG_W] = seg(12'h300, 6'h14, 1'h0, 3'h7);
		a2[0+:SEG_W] = seg(12'h101, 6'h14, 1'h0, 3'h7);
		a2[SEG_W+:SEG_W] = seg(12'h102, 6'h14, 1'h0, 3'h6);
		n2 = a2;
		send(1);
		wait_n(4);
		for (int i = 0; i < N_ST1; i++) `CHECK(sel[i*SEL_W+:SEL_W], {1'h1, e1[i*SEG_W+:SEG_W]})
		`CHECK(sel[6*SEL_W+:SEL_W], {1'h1, e2[0+:SEG_W]})
		`CHECK(sel[7*SEL_W+:SEL_W], {1'h0, n2[0+:SEG_W]})
		`CHECK(sel[8*SEL_W+:SEL_W], {1'h0, n2[SEG_W+:SEG_W]})
		$display("test window done");
		lut({64'hFFFF_FFFF_FFFF_FFFF, 64'h0});
		for (int k = 0; k < 5; k++) begin
			pair(ea[k], eb[k], ba[k], bb[k], 12'h000);
			`CHECK(q23[0], ex[k])
			`CHECK(q24[0], ex[k])
		end
		@(posedge clk);
		eta_tol <= 6'h0A;
		pair(6'h14, 6'h1E, 1'h0, 1'h0, 12'h000);
		`CHECK(q23[0], 1'h1)
		`CHECK(q24[0], 1'h1)
		`CHECK(q34[0], 1'h1)
		$display("test eta done");
		clr();
		a1[0+:SEG_W] = seg(12'h000, 6'h14, 1'h0, 3'h7);
		a1[SEG_W+:SEG_W] = seg(12'h000, 6'h3C, 1'h0, 3'h6);
		a2[0+:SEG_W] = seg(12'h000, 6'h14, 1'h0, 3'h7);
		a3[0+:SEG_W] = a2[0+:SEG_W];
		ab[0+:SEG_W] = seg(12'h000, 6'h00, 1'h0, 3'h7);
		g = 3'h1;
		send(3);
		wait_n(5);
		`CHECK(q12[6+:2], 2'h3)
		`CHECK(q13[6+:2], 2'h3)
		`CHECK(qb2[0+:2], 2'h3)
		g = 3'h0;
		send(3);
		wait_n(5);
		`CHECK(q12[6+:2], 2'h0)
		`CHECK(q12[0+:2], 2'h3)
		$display("test ghost done");
		lut({4{32'hFFFF_0000}});
		pair(6'h14, 6'h14, 1'h0, 1'h0, 12'h000);
		`CHECK(q23[0], 1'h1)
		pair(6'h14, 6'h14, 1'h0, 1'h0, 12'h400);
		`CHECK(q23[0], 1'h0)
		$display("test phi done");
		@(posedge clk);
		resetn <= 1'h0;
		wait_n(1);
		`CHECK(sel, '0)
		`CHECK(q12, '0)
		@(posedge clk);
		resetn <= 1'h1;
		$display("test reset done");
		end_sim();
	end
endmodule : tb_tspm_top
